// File: dv/mhcp_host.sv
/* Host CPU model driving the port pins with slow strobes.
   Assumes ref_clk at 125 MHz; strobes are timed in its cycles. */
`timescale 1ns/1ns
`default_nettype none
module mhcp_host (
    input  wire logic                 ref_clk,
    input  wire logic                 bus8,
    input  wire logic [15:0]          bus_d_out,
    output var  mhcp_pkg::mhcp_pins_t pins
);
    import mhcp_pkg::*;
    initial pins = '{1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 16'h0000};
    // Six clocks low and high leave margin over the three-flop sampler.
    task automatic cyc(input logic rd, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        pins = '{1'b0, !rd, rd, bus8, a, d};
        repeat (6) @(posedge ref_clk);
        #1 q = bus_d_out;
        // A released data line shows the inverse, never a stale value.
        pins = '{1'b1, 1'b1, 1'b1, bus8, a, ~d};
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : cyc
endmodule : mhcp_host
`default_nettype wire

// File: dv/mhcp_port_sva.sv
/* Checker of the host port pins and axis outputs.
   Assumes one clock domain; bound to the port module. */
`timescale 1ns/1ns
`default_nettype none
module mhcp_port_sva #(parameter int AXES = 2) (
    input wire logic                             ref_clk,
    input wire logic                             rst,
    input wire mhcp_pkg::mhcp_pins_t             pins,
    input wire logic [15:0]                      bus_d_out,
    input wire logic                             bus_d_oe,
    input wire mhcp_pkg::mhcp_speed_t [AXES-1:0] speed,
    input wire mhcp_pkg::mhcp_ctrl_t  [AXES-1:0] ctrl
);
    import mhcp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence rd_on; !pins.cs_n && !pins.rd_n; endsequence
    sequence rd_off; pins.cs_n || pins.rd_n; endsequence
    sequence wr_quiet; pins.wr_n [*8]; endsequence
    AST_OE_ON: assert property (rd_on [*4] |-> bus_d_oe)
        else $error("read enable missing");
    AST_OE_OFF: assert property (rd_off [*4] |-> !bus_d_oe)
        else $error("read enable without strobe");
    AST_BYTE_HI: assert property (pins.bus8 [*5] |-> bus_d_out[15:8] == 0)
        else $error("upper byte driven in byte mode");
    AST_ACC: assert property (speed[0].accel % ACC_FACTOR == 0)
        else $error("acceleration not a multiple");
    AST_DEC: assert property (speed[1].decel % ACC_FACTOR == 0)
        else $error("deceleration not a multiple");
    AST_GO: assert property (ctrl[0].drive_go |=> !ctrl[0].drive_go)
        else $error("start pulse too long");
    AST_STOP: assert property (ctrl[1].instant_stop |=> !ctrl[1].instant_stop)
        else $error("stop pulse too long");
    AST_QUIET: assert property (wr_quiet |-> $stable(speed) && !ctrl[0].drive_go)
        else $error("axis change without a write");
endmodule : mhcp_port_sva
bind mhcp_port mhcp_port_sva #(.AXES(AXES)) u_sva (.ref_clk(ref_clk),
    .rst(rst), .pins(pins), .bus_d_out(bus_d_out), .bus_d_oe(bus_d_oe),
    .speed(speed), .ctrl(ctrl));
`default_nettype wire

// File: dv/mhcp_port_tb_top.sv
/* Self-checking bench of the host command port.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module mhcp_port_tb_top;
    import mhcp_pkg::*;
    logic              ref_clk = 1'b0, rst = 1'b1, bus8 = 1'b0, ip = 1'b0;
    logic [31:0]       seed = 32'h5e26_4853, cv = 32'h0000_0000;
    int                bad_count = 0, checked = 0, cycles = 0;
    logic [15:0]       bus_d_out;
    logic              bus_d_oe;
    mhcp_pins_t        pins;
    mhcp_speed_t [1:0] speed;
    mhcp_ctrl_t  [1:0] ctrl;
    logic [55:0]       pcnt;
    logic [47:0]       fin;
    mhcp_port #(.AXES(2)) DUT (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .bus_d_out(bus_d_out), .bus_d_oe(bus_d_oe), .interp_mode(ip),
        .drive_done(2'b00), .cur_speed(cv), .cur_accel(32'h0000_0000),
        .axis_errors(32'h0000_0000), .axis_events(32'h0000_0000),
        .speed(speed), .ctrl(ctrl), .pulse_count(pcnt), .finish_point(fin));
    mhcp_host host (.ref_clk(ref_clk), .bus8(bus8), .bus_d_out(bus_d_out),
        .pins(pins));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Jerk divides before scaling, so the bench picks an exact divisor.
    function automatic logic [31:0] want(int i, logic [31:0] p, m);
        case (i)
            2, 3: return p * ACC_FACTOR * m;
            4: return JERK_NUM / p * m;
            default: return p * m;
        endcase
    endfunction : want
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [9:0] c);
        logic [15:0] q;
        host.cyc(1'b0, 4'h0, {6'h00, c}, q);
    endtask : cmd
    task automatic wr32(input logic [9:0] c, input logic [31:0] v);
        logic [15:0] q;
        host.cyc(1'b0, 4'h6, v[15:0], q);
        host.cyc(1'b0, 4'h7, v[31:16], q);
        cmd(c);
    endtask : wr32
    task automatic rd32(input logic [9:0] c, output logic [31:0] v);
        cmd(c);
        host.cyc(1'b1, 4'h6, 16'h0000, v[15:0]);
        host.cyc(1'b1, 4'h7, 16'h0000, v[31:16]);
    endtask : rd32
    task automatic stat(input logic [3:0] a, input logic [15:0] m, e);
        logic [15:0] q;
        host.cyc(1'b1, a, 16'h0000, q);
        chk({16'h0000, q & m}, {16'h0000, e});
    endtask : stat
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        logic [31:0] p [5];
        logic [7:0]  code [5] = '{8'h04, 8'h05, 8'h02, 8'h03, 8'h01};
        logic [31:0] v, w, m;
        logic [15:0] lo, hi;
        cv = rnd();
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        wr32(10'h100, 32'h0000_3E80);
        m = RANGE_BASE / 32'h0000_3E80;
        for (int i = 0; i < 5; i++) begin
            p[i] = (i == 4) ? 32'h0000_007D : rnd() % 32'h0000_1F40 + 1;
            wr32({2'b01, code[i]}, p[i]);
        end
        chk(speed[0].init_pps, want(0, p[0], m));
        chk(speed[0].drive_pps, want(1, p[1], m));
        chk(speed[0].accel, want(2, p[2], m));
        chk(speed[0].decel, want(3, p[3], m));
        chk(speed[0].jerk, want(4, p[4], m));
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? {4'h0, PULSE_MAX} : rnd() & 32'h0FFF_FFFF;
            wr32(10'h106, v);
            chk({4'h0, pcnt[27:0]}, v);
        end
        $display("speed and pulse tests done");
        ip = 1'b1;
        wr32(10'h306, 32'hFF80_0000);
        chk({8'h00, fin[47:24]}, 32'h0080_0000);
        rd32(10'h114, w);
        chk(w, {8'h00, MX_LIMIT});
        cmd(10'h13E);
        rd32(10'h114, w);
        chk(w, 32'h0000_0000);
        ip = 1'b0;
        v = rnd();
        wr32(10'h109, v);
        rd32(10'h110, w);
        chk({16'h0000, w[31:16]}, {16'h0000, v[31:16]});
        chk({16'h0000, w[15:0]}, {16'h0000, v[15:0]});
        bus8 = 1'b1;
        host.cyc(1'b1, 4'hC, 16'h0000, lo);
        host.cyc(1'b1, 4'hD, 16'h0000, hi);
        host.cyc(1'b0, 4'h1, 16'h0002, w[15:0]);
        host.cyc(1'b0, 4'h0, 16'h000F, w[15:0]);
        bus8 = 1'b0;
        chk({16'h0000, hi[7:0], lo[7:0]}, {16'h0000, v[15:0]});
        $display("read data tests done");
        cmd(10'h224);
        cmd(10'h223);
        stat(4'h1, 16'h0041, 16'h0040);
        cmd(10'h225);
        stat(4'h1, 16'h0003, 16'h0003);
        cmd(10'h10F);
        stat(4'h1, 16'h0001, 16'h0000);
        rd32(10'h212, w);
        chk(w, {16'h0000, cv[31:16]});
        host.cyc(1'b0, 4'h1, 16'h0000, lo);
        stat(4'h1, 16'h0003, 16'h0003);
        cmd(10'h120);
        stat(4'h0, 16'h0003, 16'h0003);
        cmd(10'h227);
        cmd(10'h20F);
        stat(4'h1, 16'h0011, 16'h0010);
        $display("drive tests done");
        report_and_stop();
    end
endmodule : mhcp_port_tb_top
`default_nettype wire

// File: verilog/mhcp_axis.sv
/*
 * One axis: parameter store, drive start/stop sequencing and speed formulas.
 * Assumes commands arrive as one-cycle pulses from the host port decoder.
 */
`timescale 1ns/1ns
`default_nettype none
module mhcp_axis (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire mhcp_pkg::mhcp_cmd_t   cmd,
    input  wire logic                  drive_done,
    output var  mhcp_pkg::mhcp_speed_t speed,
    output var  mhcp_pkg::mhcp_ctrl_t  ctrl,
    output logic [31:0]                lp,
    output logic [31:0]                ep,
    output logic [27:0]                pulse_count,
    output logic [23:0]                finish_point,
    output logic [15:0]                status_one
);
    import mhcp_pkg::*;

    typedef struct packed {
        logic [31:0] range_p;
        logic [15:0] jerk;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] sv;
        logic [15:0] v;
        logic [27:0] pulse;
        logic [23:0] finish;
        logic [27:0] decpt;
        logic [23:0] center;
        logic [31:0] lp;
        logic [31:0] ep;
        logic [31:0] compp;
        logic [31:0] compm;
        logic [15:0] aoff;
        logic        driving;
        logic        held;
        logic        pending;
        logic [7:0]  pend_code;
        logic [2:0]  term;
        mhcp_speed_t speed;
        mhcp_ctrl_t  ctrl;
    } mhcp_axis_state_t;

    mhcp_axis_state_t state_reg;
    mhcp_axis_state_t state_next;
    logic [31:0]      mult;
    logic [31:0]      jdiv;
    logic [7:0]       start_code;
    logic             start_now;

    always_comb begin
        state_next = state_reg;
        start_code = cmd.code;
        start_now  = 1'b0;
        // Speed multiple from the range parameter; zero range gives zero.
        mult = (state_reg.range_p == 32'h0000_0000) ? 32'h0000_0000
             : RANGE_BASE / state_reg.range_p;
        jdiv = (state_reg.jerk == 16'h0000) ? 32'h0000_0000
             : JERK_NUM / {16'h0000, state_reg.jerk};
        state_next.speed.init_pps  = 32'({16'h0000, state_reg.sv} * mult); // [RULE12]
        state_next.speed.drive_pps = 32'({16'h0000, state_reg.v} * mult); // [RULE12]
        state_next.speed.accel =
            32'({16'h0000, state_reg.accel} * ACC_FACTOR * mult); // [RULE13]
        state_next.speed.decel =
            32'({16'h0000, state_reg.decel} * ACC_FACTOR * mult); // [RULE14]
        state_next.speed.jerk = 32'(jdiv * mult); // [RULE15]
        state_next.ctrl = '0;
        state_next.ctrl.dir_neg = state_reg.ctrl.dir_neg;
        state_next.ctrl.fixed   = state_reg.ctrl.fixed;
        if (cmd.valid) begin
            unique case (cmd.code)
                CMD_RANGE:  state_next.range_p = cmd.data;
                CMD_JERK:   state_next.jerk    = cmd.data[15:0];
                CMD_ACCEL:  state_next.accel   = cmd.data[15:0];
                CMD_DECEL:  state_next.decel   = cmd.data[15:0];
                CMD_SV:     state_next.sv      = cmd.data[15:0];
                CMD_V:      state_next.v       = cmd.data[15:0];
                CMD_PULSE: begin
                    if (cmd.interp) begin
                        state_next.finish = cmd.data[23:0]; // [RULE6]
                    end else begin
                        state_next.pulse = cmd.data[27:0]; // [RULE5]
                    end
                end
                CMD_DECPT:  state_next.decpt  = cmd.data[27:0];
                CMD_CENTER: state_next.center = cmd.data[23:0];
                CMD_WR_LP:  state_next.lp     = cmd.data; // [RULE18]
                CMD_WR_EP:  state_next.ep     = cmd.data; // [RULE18]
                CMD_COMPP:  state_next.compp  = cmd.data;
                CMD_COMPM:  state_next.compm  = cmd.data;
                CMD_AOFF:   state_next.aoff   = cmd.data[15:0];
                CMD_FIX_P, CMD_FIX_N, CMD_CONT_P, CMD_CONT_N: begin
                    if (state_reg.held) begin
                        state_next.pending   = 1'b1; // [RULE10]
                        state_next.pend_code = cmd.code;
                    end else begin
                        start_now = 1'b1; // [RULE9]
                    end
                end
                CMD_HOLD:   state_next.held = 1'b1; // [RULE10]
                CMD_REL: begin
                    state_next.held    = 1'b0; // [RULE11]
                    state_next.term    = 3'h0;
                    state_next.pending = 1'b0;
                    start_now          = state_reg.pending;
                    start_code         = state_reg.pend_code;
                end
                CMD_DSTOP: begin
                    if (state_reg.driving) begin
                        state_next.ctrl.decel_stop = 1'b1; // [RULE11]
                        state_next.term[1]         = 1'b1;
                    end
                end
                CMD_ISTOP: begin
                    state_next.ctrl.instant_stop = 1'b1; // [RULE11]
                    state_next.driving           = 1'b0;
                    if (state_reg.driving) begin
                        state_next.term[2] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (start_now) begin
            state_next.driving        = 1'b1;
            state_next.ctrl.drive_go  = 1'b1;
            state_next.ctrl.dir_neg   = start_code[0];
            state_next.ctrl.fixed     = ~start_code[1];
        end
        // A finish report in the same cycle as a status clear still counts, unless that clear starts a pending drive.
        if (drive_done && state_reg.driving && !start_now) begin
            state_next.driving = 1'b0;
            state_next.term[0] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign speed        = state_reg.speed;
    assign ctrl         = state_reg.ctrl;
    assign lp           = state_reg.lp;
    assign ep           = state_reg.ep;
    assign pulse_count  = state_reg.pulse;
    assign finish_point = state_reg.finish;
    assign status_one   = {9'h000, state_reg.pending, state_reg.held,
                           state_reg.term, state_reg.ctrl.dir_neg,
                           state_reg.driving};
endmodule : mhcp_axis
`default_nettype wire

// File: verilog/mhcp_pkg.sv
/*
 * Constants and carrier types for the motion host command port.
 * Assumes a single 125 MHz clock domain and a 16-bit or 8-bit host bus.
 */
`default_nettype none
package mhcp_pkg;
    // Register addresses in 16-bit bus mode (host address bits 2..0).
    localparam logic [2:0] ADDR_CMD       = 3'h0;
    localparam logic [2:0] ADDR_MODE1     = 3'h1;
    localparam logic [2:0] ADDR_MODE2     = 3'h2;
    localparam logic [2:0] ADDR_MODE3     = 3'h3;
    localparam logic [2:0] ADDR_WDATA_LO  = 3'h6;
    localparam logic [2:0] ADDR_WDATA_HI  = 3'h7;
    localparam logic [2:0] ADDR_MAIN_STAT = 3'h0;
    localparam logic [2:0] ADDR_STAT_ONE  = 3'h1;
    localparam logic [2:0] ADDR_STAT_TWO  = 3'h2;
    localparam logic [2:0] ADDR_STAT_THR  = 3'h3;
    localparam logic [2:0] ADDR_RDATA_LO  = 3'h6;
    localparam logic [2:0] ADDR_RDATA_HI  = 3'h7;
    // Command word fields.
    localparam int AXIS_X_BIT = 8;
    localparam int AXIS_Y_BIT = 9;
    // Command codes.
    localparam logic [7:0] CMD_RANGE  = 8'h00;
    localparam logic [7:0] CMD_JERK   = 8'h01;
    localparam logic [7:0] CMD_ACCEL  = 8'h02;
    localparam logic [7:0] CMD_DECEL  = 8'h03;
    localparam logic [7:0] CMD_SV     = 8'h04;
    localparam logic [7:0] CMD_V      = 8'h05;
    localparam logic [7:0] CMD_PULSE  = 8'h06;
    localparam logic [7:0] CMD_DECPT  = 8'h07;
    localparam logic [7:0] CMD_CENTER = 8'h08;
    localparam logic [7:0] CMD_WR_LP  = 8'h09;
    localparam logic [7:0] CMD_WR_EP  = 8'h0A;
    localparam logic [7:0] CMD_COMPP  = 8'h0B;
    localparam logic [7:0] CMD_COMPM  = 8'h0C;
    localparam logic [7:0] CMD_AOFF   = 8'h0D;
    localparam logic [7:0] CMD_NOP    = 8'h0F;
    localparam logic [7:0] CMD_RD_LP  = 8'h10;
    localparam logic [7:0] CMD_RD_EP  = 8'h11;
    localparam logic [7:0] CMD_RD_CV  = 8'h12;
    localparam logic [7:0] CMD_RD_CA  = 8'h13;
    localparam logic [7:0] CMD_RD_MX  = 8'h14;
    localparam logic [7:0] CMD_FIX_P  = 8'h20;
    localparam logic [7:0] CMD_FIX_N  = 8'h21;
    localparam logic [7:0] CMD_CONT_P = 8'h22;
    localparam logic [7:0] CMD_CONT_N = 8'h23;
    localparam logic [7:0] CMD_HOLD   = 8'h24;
    localparam logic [7:0] CMD_REL    = 8'h25;
    localparam logic [7:0] CMD_DSTOP  = 8'h26;
    localparam logic [7:0] CMD_ISTOP  = 8'h27;
    localparam logic [7:0] CMD_MXCLR  = 8'h3E;
    // Speed formula constants and limits.
    localparam logic [31:0] RANGE_BASE  = 32'h007A_1200;
    localparam logic [31:0] ACC_FACTOR  = 32'h0000_007D;
    localparam logic [31:0] JERK_NUM    = 32'h03B9_ACA0;
    localparam logic [27:0] PULSE_MAX   = 28'hFFF_FFFF;
    localparam logic [23:0] MX_LIMIT    = 24'h7F_FFFF;
    // Status bit positions in axis_status_one.
    localparam int ST1_DRIVING  = 0;
    localparam int ST1_DIR_NEG  = 1;
    localparam int ST1_END_NORM = 2;
    localparam int ST1_END_DEC  = 3;
    localparam int ST1_END_INST = 4;
    localparam int ST1_HELD     = 5;
    localparam int ST1_PENDING  = 6;

    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        bus8;
        logic [3:0]  addr;
        logic [15:0] d;
    } mhcp_pins_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [31:0] data;
        logic        interp;
    } mhcp_cmd_t;

    typedef struct packed {
        logic [31:0] init_pps;
        logic [31:0] drive_pps;
        logic [31:0] accel;
        logic [31:0] decel;
        logic [31:0] jerk;
    } mhcp_speed_t;

    typedef struct packed {
        logic drive_go;
        logic dir_neg;
        logic fixed;
        logic decel_stop;
        logic instant_stop;
    } mhcp_ctrl_t;
endpackage : mhcp_pkg
`default_nettype wire

// File: verilog/mhcp_port.sv
/*
 * Host command port of a two-axis motion controller: bus decode, command
 * dispatch, read-data word pair and per-axis status selection.
 * Assumes an asynchronous parallel host bus whose strobes last several
 * ref_clk periods, and pulse generators on ref_clk reporting drive_done.
 */
// Notes on behaviour
// [RULE1] High read word returns fetched bits 31..16.
// [RULE2] Eight-bit bus splits registers into bytes.
// [RULE3] Status reads follow last mode-register axis.
// [RULE4] Axis-assigned NOP only switches status axis.
// [RULE5] Code 06 loads 28-bit pulse count.
// [RULE6] In interpolation 06 loads signed finish.
// [RULE7] Code 14 reads recorded maximum finish magnitude.
// [RULE8] Code 3E clears recorded maximum finish.
// [RULE9] Codes 20/21 start fixed-pulse drive.
// [RULE10] Codes 22/23 continuous drive; 24 holds starts.
// [RULE11] 25 releases/clears, 26 decelerates, 27 halts.
// [RULE12] Speeds equal parameter times speed multiple.
// [RULE13] Acceleration is parameter times 125 times multiple.
// [RULE14] Deceleration is parameter times 125 times multiple.
// [RULE15] Jerk is 62.5e6 over parameter, times multiple.
// [RULE16] Low read word returns fetched bits 15..0.
// [RULE17] Parameter first; command takes two or four bytes.
// [RULE18] Counter write overwrites; read copies to pair.
`timescale 1ns/1ns
`default_nettype none
module mhcp_port #(
    parameter int AXES = 2
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire mhcp_pkg::mhcp_pins_t  pins,
    output logic [15:0]                bus_d_out,
    output logic                       bus_d_oe,
    input  wire logic                  interp_mode,
    input  wire logic [AXES-1:0]       drive_done,
    input  wire logic [AXES*16-1:0]    cur_speed,
    input  wire logic [AXES*16-1:0]    cur_accel,
    input  wire logic [AXES*16-1:0]    axis_errors,
    input  wire logic [AXES*16-1:0]    axis_events,
    output var  mhcp_pkg::mhcp_speed_t [AXES-1:0] speed,
    output var  mhcp_pkg::mhcp_ctrl_t  [AXES-1:0] ctrl,
    output logic [AXES*28-1:0]         pulse_count,
    output logic [AXES*24-1:0]         finish_point
);
    import mhcp_pkg::*;

    if (AXES != 2) begin : g_bad_axes
        $error("mhcp_port serves exactly two axes");
    end

    typedef struct packed {
        mhcp_pins_t              sync1;
        mhcp_pins_t              sync2;
        mhcp_pins_t              last;
        logic [15:0]             wr0;
        logic [15:0]             wdata_lo;
        logic [15:0]             wdata_hi;
        logic                    axis_sel;
        logic [31:0]             rdata;
        logic [23:0]             mx;
        logic [15:0]             dout;
        mhcp_cmd_t [AXES-1:0]    cmd;
    } mhcp_port_state_t;

    mhcp_port_state_t   state_reg;
    mhcp_port_state_t   state_next;
    logic [AXES*32-1:0] lp_all;
    logic [AXES*32-1:0] ep_all;
    logic [AXES*16-1:0] st1_all;
    logic               wr_done;
    logic [2:0]         reg_sel;
    logic               hi_byte;
    logic [15:0]        wval;
    logic [15:0]        word;
    logic [15:0]        cmd_word;
    logic [23:0]        fin_mag;
    logic               ax;

    ////////////////////////////////////////////////////////////////////////
    // Per-axis units.

    for (genvar i = 0; i < AXES; i++) begin : g_axis
        mhcp_axis u_axis (
            .ref_clk      (ref_clk),
            .rst          (rst),
            .cmd          (state_reg.cmd[i]),
            .drive_done   (drive_done[i]),
            .speed        (speed[i]),
            .ctrl         (ctrl[i]),
            .lp           (lp_all[i*32 +: 32]),
            .ep           (ep_all[i*32 +: 32]),
            .pulse_count  (pulse_count[i*28 +: 28]),
            .finish_point (finish_point[i*24 +: 24]),
            .status_one   (st1_all[i*16 +: 16])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and command dispatch.

    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pins;
        state_next.sync2 = state_reg.sync1;
        state_next.last  = state_reg.sync2;
        for (int i = 0; i < AXES; i++) begin
            state_next.cmd[i].valid = 1'b0;
        end
        // Writes commit on the rising edge of the write strobe.
        wr_done = state_reg.sync2.wr_n && !state_reg.last.wr_n
                  && !state_reg.last.cs_n;
        if (state_reg.last.bus8) begin
            reg_sel = state_reg.last.addr[3:1]; // [RULE2]
            hi_byte = state_reg.last.addr[0];
        end else begin
            reg_sel = state_reg.last.addr[2:0];
            hi_byte = 1'b0;
        end
        unique case (reg_sel)
            ADDR_WDATA_LO: word = state_reg.wdata_lo;
            ADDR_WDATA_HI: word = state_reg.wdata_hi;
            default:       word = state_reg.wr0;
        endcase
        wval = word;
        if (!state_reg.last.bus8) begin
            wval = state_reg.last.d;
        end else if (hi_byte) begin
            wval[15:8] = state_reg.last.d[7:0]; // [RULE2]
        end else begin
            wval[7:0] = state_reg.last.d[7:0]; // [RULE2]
        end
        cmd_word = wval;
        ax       = state_reg.wr0[AXIS_Y_BIT] && !state_reg.wr0[AXIS_X_BIT];
        fin_mag  = 24'h00_0000;
        if (wr_done) begin
            unique case (reg_sel)
                ADDR_WDATA_LO: state_next.wdata_lo = wval; // [RULE17]
                ADDR_WDATA_HI: state_next.wdata_hi = wval; // [RULE17]
                ADDR_MODE1, ADDR_MODE2, ADDR_MODE3: begin
                    state_next.axis_sel = ax; // [RULE3]
                end
                ADDR_CMD: begin
                    state_next.wr0 = wval;
                end
                default: ;
            endcase
        end
        // A command runs once its code byte is in; on an 8-bit bus that is
        // the low byte, so the axis byte has to be written first.
        if (wr_done && reg_sel == ADDR_CMD && !hi_byte) begin
            for (int i = 0; i < AXES; i++) begin
                state_next.cmd[i].valid  = cmd_word[AXIS_X_BIT + i];
                state_next.cmd[i].code   = cmd_word[7:0];
                state_next.cmd[i].interp = interp_mode;
                state_next.cmd[i].data   = {state_reg.wdata_hi,
                                            state_reg.wdata_lo}; // [RULE17]
                if (cmd_word[7:0] inside {CMD_JERK, CMD_ACCEL, CMD_DECEL,
                                          CMD_SV, CMD_V, CMD_AOFF}) begin
                    state_next.cmd[i].data[31:16] = 16'h0000; // [RULE17]
                end
            end
            ax = cmd_word[AXIS_Y_BIT] && !cmd_word[AXIS_X_BIT];
            unique case (cmd_word[7:0])
                CMD_NOP: begin
                    if (cmd_word[AXIS_Y_BIT] || cmd_word[AXIS_X_BIT]) begin
                        state_next.axis_sel = ax; // [RULE4]
                    end
                end
                CMD_RD_LP: state_next.rdata = lp_all[ax*32 +: 32]; // [RULE18]
                CMD_RD_EP: state_next.rdata = ep_all[ax*32 +: 32]; // [RULE18]
                CMD_RD_CV: state_next.rdata = {16'h0000, cur_speed[ax*16 +: 16]};
                CMD_RD_CA: state_next.rdata = {16'h0000, cur_accel[ax*16 +: 16]};
                CMD_RD_MX: state_next.rdata = {8'h00, state_reg.mx}; // [RULE7]
                CMD_MXCLR: state_next.mx = 24'h00_0000; // [RULE8]
                CMD_PULSE: begin
                    // The largest finish magnitude is kept for sub-chips.
                    if (interp_mode) begin
                        if (state_reg.wdata_hi[7]) begin
                            fin_mag = 24'(-{state_reg.wdata_hi[7:0],
                                            state_reg.wdata_lo});
                        end else begin
                            fin_mag = {state_reg.wdata_hi[7:0],
                                       state_reg.wdata_lo};
                        end
                        if (fin_mag > MX_LIMIT) begin
                            fin_mag = MX_LIMIT;
                        end
                        if (fin_mag > state_reg.mx) begin
                            state_next.mx = fin_mag; // [RULE7]
                        end
                    end
                end
                default: ;
            endcase
        end
        // Read path: output word is registered while the host reads.
        unique case (reg_sel)
            ADDR_MAIN_STAT: word = {14'h0000, st1_all[16 + ST1_DRIVING],
                                    st1_all[ST1_DRIVING]};
            ADDR_STAT_ONE:  word = st1_all[state_reg.axis_sel*16 +: 16]; // [RULE3]
            ADDR_STAT_TWO:  word = axis_errors[state_reg.axis_sel*16 +: 16]; // [RULE3]
            ADDR_STAT_THR:  word = axis_events[state_reg.axis_sel*16 +: 16]; // [RULE3]
            ADDR_RDATA_LO:  word = state_reg.rdata[15:0]; // [RULE16]
            ADDR_RDATA_HI:  word = state_reg.rdata[31:16]; // [RULE1]
            default:        word = 16'h0000;
        endcase
        if (state_reg.last.bus8) begin
            state_next.dout = hi_byte ? {8'h00, word[15:8]}
                                      : {8'h00, word[7:0]}; // [RULE2]
        end else begin
            state_next.dout = word;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.sync1.cs_n <= 1'b1;
            state_reg.sync1.rd_n <= 1'b1;
            state_reg.sync1.wr_n <= 1'b1;
            state_reg.sync2.cs_n <= 1'b1;
            state_reg.sync2.rd_n <= 1'b1;
            state_reg.sync2.wr_n <= 1'b1;
            state_reg.last.cs_n  <= 1'b1;
            state_reg.last.rd_n  <= 1'b1;
            state_reg.last.wr_n  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus_d_out = state_reg.dout;
    assign bus_d_oe  = !state_reg.last.cs_n && !state_reg.last.rd_n;
endmodule : mhcp_port
`default_nettype wire
